// ---- wd_params.svh ----
/*
 * Constants of the window watchdog supervisor: SPI frame layout, the service
 * trigger register, window frames, filter and pulse times and the clock rate.
 * Assumes it is included by bare name from the package and the design modules.
 */
`ifndef WD_PARAMS_SVH
`define WD_PARAMS_SVH

// core clock
`define WD_CLK_HZ           50000000
`define WD_CYC_PER_MS       (`WD_CLK_HZ / 1000)
`define WD_CYC_PER_US       (`WD_CLK_HZ / 1000000)

// service trigger register and its key value
`define WD_TRIG_ADDR        7'h15
`define WD_TRIG_KEY         8'hFF

// spi frame: 7 address bits, write flag, 8 data bits, msb first
`define WD_SPI_FRAME_BITS   5'h10
`define WD_SPI_ADDR_MSB     15
`define WD_SPI_ADDR_LSB     9
`define WD_SPI_WRITE_BIT    8
`define WD_SPI_DATA_MSB     7

// window frames in ms, printed as minimum and maximum
`define WD_WIN_GND_MIN_MS   32
`define WD_WIN_GND_MAX_MS   48
`define WD_WIN_VCC_MIN_MS   480
`define WD_WIN_VCC_MAX_MS   720
`define WD_WIN_OPEN_MIN_MS  4800
`define WD_WIN_OPEN_MAX_MS  7200

// long initial window after entering an active mode
`define WD_INIT_WIN_MS      7200

// trigger glitch filter and watchdog reset pulse
`define WD_TRIG_FILTER_US   20
`define WD_RESET_PULSE_US   50

// strap capture waits for the synchronisers to fill
`define WD_STRAP_WAIT       2'h3

// synchronised pin vector positions
`define WD_PIN_SELECT       0
`define WD_PIN_WINDOW       1
`define WD_PIN_WIN_OPEN     2
`define WD_PIN_TRIGGER      3
`define WD_PIN_VCC_OK       4
`define WD_PIN_COUNT        5

`endif

// ---- wd_pkg.sv ----
/*
 * Types of the window watchdog supervisor: watchdog states and the packed
 * state records of the top module and the spi frame receiver.
 * Assumes wd_params.svh is on the include path.
 */
`include "wd_params.svh"

package wd_pkg;

	typedef enum logic [2:0] {
		st_idle,
		st_initial,
		st_closed,
		st_open,
		st_error
	} wd_state_e;

	typedef logic [31:0] cyc_t;

	typedef struct packed {
		logic [`WD_PIN_COUNT-1:0] sync1;
		logic [`WD_PIN_COUNT-1:0] sync2;
		logic [1:0]               strap_wait;
		logic                     strap_done;
		logic                     spi_mode;
		logic                     trig_level;
		logic [15:0]              filt_cnt;
		logic                     active_prev;
		wd_state_e                state;
		cyc_t                     cnt;
		logic                     wd_rst_b;
		logic                     proc_rst_b;
	} top_state_s;

	typedef struct packed {
		logic [15:0] shift;
		logic [4:0]  bits;
		logic        sck_prev;
		logic        cs_prev_b;
		logic        trigger;
	} spi_state_s;

endpackage

// ---- wd_link_if.sv ----
/*
 * Link between the supervisor core and its spi frame receiver: the
 * synchronised spi pins and the service trigger pulse.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/10ps

interface wd_link_if;
	logic spi_en;   // spi control selected by the strap
	logic sck;      // synchronised spi clock
	logic sdi;      // synchronised serial data in
	logic cs_b;     // synchronised chip select
	logic trigger;  // one-cycle pulse: valid service write seen

	modport core
	(
		output spi_en,
		output sck,
		output sdi,
		output cs_b,
		input  trigger
	);

	modport rx
	(
		input  spi_en,
		input  sck,
		input  sdi,
		input  cs_b,
		output trigger
	);
endinterface

// ---- wd_spi_rx.sv ----
/*
 * Spi frame receiver: shifts in 16-bit frames on rising sck while chip
 * select is low and pulses trigger when a frame writes the key value to the
 * service trigger register.
 * Assumes pins arrive already synchronised to ref_clk and sck is well below
 * a quarter of ref_clk.
 */
`timescale 1ns/10ps

module wd_spi_rx
(
	input  wire logic ref_clk,
	input  wire logic rst_b,
	wd_link_if.rx     link
);
	import wd_pkg::*;

	spi_state_s s;
	spi_state_s next_s;
	logic       frame_ok;

	// frame decode on chip select release; partial or long frames are dropped
	always_comb
	begin
		next_s = s;
		next_s.trigger = 1'b0;
		next_s.sck_prev = link.sck;
		next_s.cs_prev_b = link.cs_b;
		frame_ok = (s.bits == `WD_SPI_FRAME_BITS)
			&& (s.shift[`WD_SPI_ADDR_MSB:`WD_SPI_ADDR_LSB] == `WD_TRIG_ADDR)
			&& s.shift[`WD_SPI_WRITE_BIT]
			&& (s.shift[`WD_SPI_DATA_MSB:0] == `WD_TRIG_KEY);
		if (!link.spi_en || link.cs_b)
		begin
			next_s.bits = 5'h00;
		end
		else if (link.sck && !s.sck_prev)
		begin
			next_s.shift = {s.shift[14:0], link.sdi};
			if (s.bits != 5'h1F)
			begin
				next_s.bits = s.bits + 5'h01;  // saturates so long frames stay invalid
			end
		end
		if (link.spi_en && link.cs_b && !s.cs_prev_b && frame_ok)
		begin
			next_s.trigger = 1'b1;
		end
	end

	// state register
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s <= '{shift: 16'h0000, bits: 5'h00, sck_prev: 1'b0, cs_prev_b: 1'b1,
				trigger: 1'b0};
		end
		else
		begin
			s <= next_s;
		end
	end

	assign link.trigger = s.trigger;

endmodule

// ---- window_watchdog_supervisor.sv ----
/*
 * Window watchdog supervisor: strap capture of the control method, window
 * selection, trigger filtering, the window state machine and both reset
 * outputs. Spi frames are decoded by wd_spi_rx.
 * Assumes pins are asynchronous to ref_clk; active_mode, restart_mode and
 * reset_as_wd_event come from logic on ref_clk.
 */
// Functional notes
// - strap low at power-up selects pin control
// - strap high or open selects spi control
// - pin control: window from window-select strap
// - pin control: trigger pin activity services watchdog
// - watchdog error drives watchdog reset low
// - spi: writing FFh to 15h restarts timer
// - spi: processor reset may become watchdog output
// - long initial window on entering active modes
// - pin control: processor reset high when regulator good; held low here while restart_mode is set
// - window frames: 32-48 ms, 480-720 ms, 4.8-7.2 s
// - window split half closed, half open
// - either trigger edge restarts, glitches filtered
`timescale 1ns/10ps
`include "wd_params.svh"

module window_watchdog_supervisor
#(
	parameter wd_pkg::cyc_t WIN_GND_CYC  =
		((`WD_WIN_GND_MIN_MS + `WD_WIN_GND_MAX_MS) / 2) * `WD_CYC_PER_MS,
	parameter wd_pkg::cyc_t WIN_VCC_CYC  =
		((`WD_WIN_VCC_MIN_MS + `WD_WIN_VCC_MAX_MS) / 2) * `WD_CYC_PER_MS,
	parameter wd_pkg::cyc_t WIN_OPEN_CYC =
		((`WD_WIN_OPEN_MIN_MS + `WD_WIN_OPEN_MAX_MS) / 2) * `WD_CYC_PER_MS,
	parameter wd_pkg::cyc_t INIT_WIN_CYC = `WD_INIT_WIN_MS * `WD_CYC_PER_MS
)
(
	input  wire logic ref_clk,
	input  wire logic rst_b,
	input  wire logic control_select_pin,
	input  wire logic window_select_pin,
	input  wire logic window_select_open,
	input  wire logic service_trigger_pin,
	input  wire logic vcc_above_uv,
	input  wire logic active_mode,
	input  wire logic restart_mode,
	input  wire logic reset_as_wd_event,
	output logic      spi_mode,
	output logic      watchdog_reset_out_b,
	output logic      processor_reset_out_b
);
	import wd_pkg::*;

	localparam logic [15:0] FILTER_CYC   = 16'(`WD_TRIG_FILTER_US * `WD_CYC_PER_US);
	localparam cyc_t        PULSE_CYC    = cyc_t'(`WD_RESET_PULSE_US * `WD_CYC_PER_US);

	top_state_s s;
	top_state_s next_s;
	wd_link_if  link ();
	cyc_t       win_cyc;
	cyc_t       closed_cyc;
	cyc_t       open_cyc;
	logic       pin_event;
	logic       service;
	logic       active;
	wd_state_e  st;

	// spi pins share the strap and watchdog pins once spi control is chosen
	assign link.spi_en = s.strap_done && s.spi_mode;
	assign link.sck    = s.sync2[`WD_PIN_WINDOW];
	assign link.sdi    = s.sync2[`WD_PIN_TRIGGER];
	assign link.cs_b   = s.sync2[`WD_PIN_SELECT];

	wd_spi_rx u_spi_rx
	(
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.link    (link)
	);

	// window length; spi control has no pin to read, so the middle frame is used
	always_comb
	begin
		if (s.spi_mode)
		begin
			win_cyc = WIN_VCC_CYC;
		end
		else if (s.sync2[`WD_PIN_WIN_OPEN])
		begin
			win_cyc = WIN_OPEN_CYC;
		end
		else if (s.sync2[`WD_PIN_WINDOW])
		begin
			win_cyc = WIN_VCC_CYC;
		end
		else
		begin
			win_cyc = WIN_GND_CYC;
		end
		closed_cyc = win_cyc >> 1;
		open_cyc   = win_cyc - closed_cyc;
	end

	// next state of the whole supervisor
	always_comb
	begin
		next_s = s;
		pin_event = 1'b0;
		next_s.sync1 = {vcc_above_uv, service_trigger_pin, window_select_open,
			window_select_pin, control_select_pin};
		next_s.sync2 = s.sync1;

		// strap is caught once, after the synchronisers hold real pin levels
		if (!s.strap_done)
		begin
			next_s.strap_wait = s.strap_wait + 2'h1;
			if (s.strap_wait == `WD_STRAP_WAIT)
			begin
				next_s.strap_done = 1'b1;
				next_s.spi_mode = s.sync2[`WD_PIN_SELECT];
				next_s.trig_level = s.sync2[`WD_PIN_TRIGGER];
			end
		end

		// trigger level must differ for the whole filter time to count
		if (s.strap_done && !s.spi_mode && (s.sync2[`WD_PIN_TRIGGER] != s.trig_level))
		begin
			if (s.filt_cnt >= FILTER_CYC - 16'h0001)
			begin
				next_s.filt_cnt = 16'h0000;
				next_s.trig_level = s.sync2[`WD_PIN_TRIGGER];
				pin_event = 1'b1;
			end
			else
			begin
				next_s.filt_cnt = s.filt_cnt + 16'h0001;
			end
		end
		else
		begin
			next_s.filt_cnt = 16'h0000;
		end

		service = s.strap_done && (s.spi_mode ? link.trigger : pin_event);
		active = s.strap_done && active_mode;
		next_s.active_prev = active;
		next_s.cnt = s.cnt + 32'h1;

		// window state machine; the host keeps triggers inside the open window
		unique case (s.state)
			st_idle:
			begin
				next_s.cnt = 32'h0;
				if (active && !s.active_prev)
				begin
					next_s.state = st_initial;
				end
			end
			st_initial:
			begin
				if (service)
				begin
					next_s.state = st_closed;
					next_s.cnt = 32'h0;
				end
				else if (s.cnt >= INIT_WIN_CYC - 32'h1)
				begin
					next_s.state = st_error;
					next_s.cnt = 32'h0;
				end
			end
			st_closed:
			begin
				if (service)
				begin
					next_s.state = st_error;
					next_s.cnt = 32'h0;
				end
				else if (s.cnt >= closed_cyc - 32'h1)
				begin
					next_s.state = st_open;
					next_s.cnt = 32'h0;
				end
			end
			st_open:
			begin
				if (service)
				begin
					next_s.state = st_closed;
					next_s.cnt = 32'h0;
				end
				else if (s.cnt >= open_cyc - 32'h1)
				begin
					next_s.state = st_error;
					next_s.cnt = 32'h0;
				end
			end
			st_error:
			begin
				// the reset processor restarts, so it gets the long window again
				if (s.cnt >= PULSE_CYC - 32'h1)
				begin
					next_s.state = st_initial;
					next_s.cnt = 32'h0;
				end
			end
		endcase
		if (!active)
		begin
			next_s.state = st_idle;
			next_s.cnt = 32'h0;
		end
		st = next_s.state;

		// reset outputs come from flip-flops
		next_s.wd_rst_b = (st != st_error);
		if (s.strap_done && s.spi_mode && reset_as_wd_event)
		begin
			next_s.proc_rst_b = next_s.wd_rst_b;
		end
		else
		begin
			next_s.proc_rst_b = s.sync2[`WD_PIN_VCC_OK] && !restart_mode;
		end
	end

	// state register
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s <= '{sync1: '0, sync2: '0, strap_wait: 2'h0, strap_done: 1'b0,
				spi_mode: 1'b0, trig_level: 1'b0, filt_cnt: 16'h0000,
				active_prev: 1'b0, state: st_idle, cnt: 32'h0, wd_rst_b: 1'b1,
				proc_rst_b: 1'b0};
		end
		else
		begin
			s <= next_s;
		end
	end

	assign spi_mode              = s.spi_mode;
	assign watchdog_reset_out_b  = s.wd_rst_b;
	assign processor_reset_out_b = s.proc_rst_b;

endmodule

// ---- wd_host_model.sv ----
/* supervised host: toggles the trigger pin or sends spi service frames
 * assumes ref_clk of the supervisor; straps set by the bench */
`timescale 1ns/10ps
module wd_host_model
(
	input  wire logic ref_clk,
	output logic      cs_pin,
	output logic      sck_pin,
	output logic      sdi_pin
);
	// chip select idles high as its pull-up does
	initial
	begin
		cs_pin = 1'b1;
		sck_pin = 1'b0;
		sdi_pin = 1'b0;
	end
	// one edge on the trigger pin; the bench spaces calls into the window
	task toggle;
		@(posedge ref_clk);
		sdi_pin <= ~sdi_pin;
	endtask
	// mode 0 frame, msb first, sck at an eighth of ref_clk
	task frame(input logic [6:0] a, input logic [7:0] d);
		logic [15:0] v;
		v = {a, 1'b1, d};
		@(posedge ref_clk);
		cs_pin <= 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			sdi_pin <= v[i];
			repeat (4) @(posedge ref_clk);
			sck_pin <= 1'b1;
			repeat (4) @(posedge ref_clk);
			sck_pin <= 1'b0;
		end
		repeat (4) @(posedge ref_clk);
		cs_pin <= 1'b1;
		sdi_pin <= ~v[0]; // released line must not keep the last bit
		repeat (4) @(posedge ref_clk);
	endtask
endmodule

// ---- window_watchdog_supervisor_monitor.sv ----
/* port checker of the watchdog supervisor
 * assumes it is bound into window_watchdog_supervisor */
`timescale 1ns/10ps
`include "wd_params.svh"
module wd_monitor
#(
	parameter wd_pkg::cyc_t WIN_GND_CYC = 40
)
(
	input logic ref_clk,
	input logic rst_b,
	input logic active_mode,
	input logic restart_mode,
	input logic reset_as_wd_event,
	input logic vcc_above_uv,
	input logic spi_mode,
	input logic watchdog_reset_out_b,
	input logic processor_reset_out_b
);
	import wd_pkg::*;
	int lo;
	int hi;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// run lengths of the reset levels; counters avoid huge repetitions
	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
		begin
			lo <= 0;
			hi <= 0;
		end
		else
		begin
			lo <= watchdog_reset_out_b ? 0 : lo + 1;
			hi <= watchdog_reset_out_b ? hi + 1 : 0;
		end
	// pulse length follows the reset pulse time of the shared constants
	a_pulse_len: assert property ($rose(watchdog_reset_out_b) |->
		lo == `WD_RESET_PULSE_US * `WD_CYC_PER_US)
		else $error("watchdog reset pulse length wrong");
	a_pulse_min: assert property ($fell(watchdog_reset_out_b) |->
		!watchdog_reset_out_b [*8])
		else $error("watchdog reset pulse too short");
	a_idle_quiet: assert property (!active_mode |=> watchdog_reset_out_b)
		else $error("watchdog reset outside active modes");
	a_err_space: assert property ($fell(watchdog_reset_out_b) |->
		hi >= WIN_GND_CYC / 2)
		else $error("watchdog error inside closed time");
	a_wd_follow: assert property (spi_mode && reset_as_wd_event
		|=> processor_reset_out_b == watchdog_reset_out_b)
		else $error("processor reset not following watchdog");
	a_pin_good: assert property ((!spi_mode && vcc_above_uv && !restart_mode) [*4]
		|-> processor_reset_out_b)
		else $error("processor reset low with supply good");
	a_restart_low: assert property (restart_mode && !reset_as_wd_event
		|=> !processor_reset_out_b)
		else $error("processor reset high in restart");
	a_mode_held: assert property (spi_mode |=> spi_mode)
		else $error("control method changed");
	c_err: cover property ($fell(watchdog_reset_out_b));
	c_follow: cover property (spi_mode && reset_as_wd_event && !watchdog_reset_out_b);
	c_restart: cover property (restart_mode && !spi_mode);
endmodule
bind window_watchdog_supervisor wd_monitor #(.WIN_GND_CYC(WIN_GND_CYC)) mon
(
	.ref_clk, .rst_b, .active_mode, .restart_mode, .reset_as_wd_event,
	.vcc_above_uv, .spi_mode, .watchdog_reset_out_b, .processor_reset_out_b
);

// ---- test_window_watchdog_supervisor.sv ----
/* self-checking bench of the watchdog supervisor, short windows
 * assumes wd_host_model and the bound monitor are compiled */
`timescale 1ns/10ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_count++; \
	$display("BAD %s exp %0h got %0h", n, e, s); end end
module test_window_watchdog_supervisor;
	import wd_pkg::*;
	localparam cyc_t WG = 4000, WV = 6000, WO = 8000, WI = 5000;
	logic ref_clk = 0, rst_b = 0, active_mode = 0, restart_mode = 0;
	logic reset_as_wd_event = 0, vcc_above_uv = 1, window_select_open = 0;
	logic cs_pin, sck_pin, sdi_pin, spi_mode, wd_b, proc_b;
	int err_count = 0, comparisons = 0, cyc = 0, t0;
	always #10 ref_clk = ~ref_clk;
	// cycle count for timing, also the hang guard
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 100000)
		begin
			err_count++;
			close_out;
		end
	end
	wd_host_model host (.ref_clk(ref_clk), .cs_pin(cs_pin), .sck_pin(sck_pin), .sdi_pin(sdi_pin));
	window_watchdog_supervisor #(.WIN_GND_CYC(WG), .WIN_VCC_CYC(WV), .WIN_OPEN_CYC(WO),
		.INIT_WIN_CYC(WI)) DUT (.ref_clk(ref_clk), .rst_b(rst_b),
		.control_select_pin(cs_pin), .window_select_pin(sck_pin),
		.window_select_open(window_select_open), .service_trigger_pin(sdi_pin),
		.vcc_above_uv(vcc_above_uv), .active_mode(active_mode), .restart_mode(restart_mode),
		.reset_as_wd_event(reset_as_wd_event), .spi_mode(spi_mode),
		.watchdog_reset_out_b(wd_b), .processor_reset_out_b(proc_b));
	task close_out;
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// bounded by the hang guard
	task wait_wd(input logic v);
		while (wd_b !== v)
			step(1);
	endtask
	// straps held well past capture
	task boot(input logic cs);
		rst_b <= 0;
		active_mode <= 0;
		host.cs_pin <= cs;
		host.sck_pin <= 0;
		step(3);
		rst_b <= 1;
		step(8);
	endtask
	task pin_windows;
		cyc_t w [3];
		w = '{WG, WV, WO};
		boot(0);
		`CHK("pin mode", 1'b0, spi_mode)
		active_mode <= 1;
		for (int i = 0; i < 3; i++)
		begin
			host.sck_pin <= (i == 1);
			window_select_open <= (i == 2);
			wait_wd(1);
			t0 = cyc;
			host.toggle();
			wait_wd(0);
			`CHK("window", 1'b1, (cyc - t0) inside {[w[i] + 995 : w[i] + 1015]})
		end
	endtask
	// filter costs some 1000 cycles per pin trigger
	task pin_service;
		host.sck_pin <= 0;
		window_select_open <= 0;
		wait_wd(1);
		host.toggle();
		step(3500);
		host.toggle();
		step(1500);
		`CHK("served", 1'b1, wd_b)
		t0 = cyc;
		host.toggle();
		wait_wd(0);
		`CHK("early", 1'b1, (cyc - t0) inside {[995 : 1015]})
		t0 = cyc;
		wait_wd(1);
		`CHK("pulse", 1'b1, (cyc - t0) inside {[2495 : 2505]})
		t0 = cyc;
		host.toggle();
		step(100);
		host.toggle();
		wait_wd(0);
		`CHK("glitch", 1'b1, (cyc - t0) inside {[WI - 10 : WI + 10]})
		wait_wd(1);
		restart_mode <= 1;
		step(4);
		`CHK("restart", 1'b0, proc_b)
		restart_mode <= 0;
		vcc_above_uv <= 0;
		step(4);
		`CHK("uv", 1'b0, proc_b)
		vcc_above_uv <= 1;
		step(4);
		`CHK("good", 1'b1, proc_b)
	endtask
	// wrong data and address frames land in the open part and must not serve
	task spi_service;
		boot(1);
		`CHK("spi mode", 1'b1, spi_mode)
		active_mode <= 1;
		reset_as_wd_event <= 1;
		host.frame(7'h15, 8'hFF);
		step(4000);
		host.frame(7'h15, 8'hFE);
		host.frame(7'h14, 8'hFF);
		host.frame(7'h15, 8'hFF);
		t0 = cyc;
		wait_wd(0);
		`CHK("spi window", 1'b1, (cyc - t0) inside {[WV - 15 : WV + 10]})
		`CHK("follow", 1'b0, proc_b)
	endtask
	initial
	begin
		pin_windows;
		pin_service;
		spi_service;
		close_out;
	end
endmodule
